/* File: hdl/cce_exec.sv */
// Execution unit for table call and return, bit clear, conditional move,
// compare, debug trap and return, and interrupt disable.
// Assumes a decoder hands over one instruction at a time with its PC, a
// memory port that acknowledges each request, and APB on the core clock.
`timescale 1ns/100ps
module cce_exec
#(
   parameter bit HAS_DEBUG = 1'b1
)
(
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic RST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Instruction issue and completion.
   input wire logic INSN_VALID,
   input wire logic [31:0] INSN_WORD,
   input wire logic [31:0] INSN_PC,
   output logic INSN_READY,
   output logic DONE,
   output logic ILLEGAL,
   output logic [31:0] NEXT_PC,
   // Interrupt requests.
   input wire logic IRQ_REQ,
   input wire logic NMI_REQ,
   output logic INT_ACCEPT,
   output logic NMI_ACCEPT,
   // Memory port.
   output logic MEM_REQ,
   output logic MEM_WRITE,
   output logic MEM_HALF,
   output logic [31:0] MEM_ADDR,
   output logic [7:0] MEM_WDATA,
   input wire logic [15:0] MEM_RDATA,
   input wire logic MEM_ACK
);
   typedef enum logic [2:0] {
      S_IDLE, S_READ_A, S_READ_B, S_EXEC, S_MEM_RD, S_MEM_WR
   } cce_state_t;

   typedef struct packed {
      cce_state_t state;
      cce_pkg::cce_op_t op;
      logic [31:0] insn;
      logic [31:0] pc;
      logic [31:0] opa;
      logic [7:0] status;
      logic [31:0] tc_pc;
      logic [7:0] tc_status;
      logic [31:0] tc_base;
      logic [31:0] dbg_pc;
      logic [7:0] dbg_status;
      logic mem_req;
      logic mem_write;
      logic mem_half;
      logic [31:0] mem_addr;
      logic [7:0] mem_wdata;
      logic [2:0] bit_sel;
      logic done;
      logic illegal;
      logic int_take;
      logic nmi_take;
      logic [31:0] next_pc;
      logic [31:0] prdata;
      logic pslverr;
   } cce_regs_t;

   localparam cce_regs_t REGS_RST = '{
      state: S_IDLE,
      op: cce_pkg::OP_NONE,
      status: cce_pkg::STATUS_RST,
      tc_base: cce_pkg::BASE_RST,
      default: '0
   };

   cce_regs_t s;
   cce_regs_t n;
   logic gpr_we;
   logic [4:0] gpr_waddr;
   logic [4:0] gpr_raddr;
   logic [31:0] gpr_wdata;
   logic [31:0] gpr_rdata;
   logic int_pending;

   // Debug opcodes decode as illegal when the debug option is off.
   function automatic cce_pkg::cce_op_t decode(input logic [31:0] w);
      logic [15:0] hi;
      hi = w[31:16];
      decode = cce_pkg::OP_NONE;
      if (w == cce_pkg::OPC_TRET)
         decode = cce_pkg::OP_TRET;
      else if (w == cce_pkg::OPC_DRET && HAS_DEBUG)
         decode = cce_pkg::OP_DRET;
      else if (w == cce_pkg::OPC_IDIS)
         decode = cce_pkg::OP_IDIS;
      else if (w[15:0] == cce_pkg::OPC_DTRAP && HAS_DEBUG)
         decode = cce_pkg::OP_DTRAP;
      else if (w[15:6] == cce_pkg::OPC_TCALL)
         decode = cce_pkg::OP_TCALL;
      else if (w[10:5] == cce_pkg::OPC_CMPR)
         decode = cce_pkg::OP_CMPR;
      else if (w[10:5] == cce_pkg::OPC_CMPI)
         decode = cce_pkg::OP_CMPI;
      else if (w[15:14] == cce_pkg::OPC_BCLR_TOP && w[10:5] == cce_pkg::OPC_BCLR_D)
         decode = cce_pkg::OP_BCLR_D;
      else if (w[10:5] == cce_pkg::OPC_EXT && hi == cce_pkg::SUB_BCLR_R)
         decode = cce_pkg::OP_BCLR_R;
      else if (w[10:5] == cce_pkg::OPC_EXT && hi[10:5] == cce_pkg::SUB_MOVR && !hi[0])
         decode = cce_pkg::OP_MOVR;
      else if (w[10:5] == cce_pkg::OPC_EXT && hi[10:5] == cce_pkg::SUB_MOVI && !hi[0])
         decode = cce_pkg::OP_MOVI;
   endfunction : decode

   function automatic logic [31:0] insn_len(input cce_pkg::cce_op_t op);
      case (op)
         cce_pkg::OP_TCALL, cce_pkg::OP_CMPR, cce_pkg::OP_CMPI, cce_pkg::OP_DTRAP:
            insn_len = cce_pkg::SHORT_LEN;
         default:
            insn_len = cce_pkg::LONG_LEN;
      endcase
   endfunction : insn_len

   function automatic logic [31:0] sext5(input logic [4:0] v);
      sext5 = {{27{v[4]}}, v};
   endfunction : sext5

   function automatic logic cond_met(input logic [3:0] cc, input logic [7:0] st);
      logic c;
      logic z;
      logic sg;
      logic v;
      c = st[cce_pkg::FL_CARRY];
      z = st[cce_pkg::FL_ZERO];
      sg = st[cce_pkg::FL_SIGN];
      v = st[cce_pkg::FL_OVF];
      case (cc)
         4'h0: cond_met = v;
         4'h1: cond_met = c;
         4'h2: cond_met = z;
         4'h3: cond_met = c | z;
         4'h4: cond_met = sg;
         4'h5: cond_met = 1'b1;
         4'h6: cond_met = sg ^ v;
         4'h7: cond_met = (sg ^ v) | z;
         4'h8: cond_met = !v;
         4'h9: cond_met = !c;
         4'ha: cond_met = !z;
         4'hb: cond_met = !(c | z);
         4'hc: cond_met = !sg;
         4'hd: cond_met = st[cce_pkg::FL_SAT];
         4'he: cond_met = !(sg ^ v);
         default: cond_met = !((sg ^ v) | z);
      endcase
   endfunction : cond_met

   function automatic logic [7:0] cmp_status(input logic [31:0] a, input logic [31:0] b,
                                            input logic [7:0] st);
      logic [32:0] d;
      d = {1'b0, a} - {1'b0, b};
      cmp_status = st;
      cmp_status[cce_pkg::FL_CARRY] = d[32];
      cmp_status[cce_pkg::FL_OVF] = (a[31] != b[31]) && (d[31] != a[31]);
      cmp_status[cce_pkg::FL_SIGN] = d[31];
      cmp_status[cce_pkg::FL_ZERO] = (d[31:0] == 32'h0);
   endfunction : cmp_status

   assign int_pending = NMI_REQ || (IRQ_REQ && !s.status[cce_pkg::FL_INT_DIS]);

   always_comb
   begin
      logic [7:0] rbyte;
      logic [31:0] len;
      n = s;
      rbyte = MEM_RDATA[7:0];
      len = insn_len(s.op);
      n.done = 1'b0;
      n.illegal = 1'b0;
      n.int_take = 1'b0;
      n.nmi_take = 1'b0;
      gpr_we = 1'b0;
      gpr_waddr = s.insn[31:27];
      gpr_wdata = s.opa;
      gpr_raddr = (s.state == S_READ_A) ? s.insn[4:0] : s.insn[15:11];
      // Register access; the instruction logic below wins a same-cycle clash.
      if (PSEL && !PENABLE)
      begin
         n.pslverr = 1'b0;
         case (PADDR)
            cce_pkg::A_STATUS: n.prdata = {24'h0, s.status};
            cce_pkg::A_TC_PC: n.prdata = s.tc_pc;
            cce_pkg::A_TC_STATUS: n.prdata = {24'h0, s.tc_status};
            cce_pkg::A_TC_BASE: n.prdata = s.tc_base;
            cce_pkg::A_DBG_PC: n.prdata = s.dbg_pc;
            cce_pkg::A_DBG_STATUS: n.prdata = {24'h0, s.dbg_status};
            default:
            begin
               n.prdata = 32'h0;
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (PSEL && PENABLE && PWRITE && !s.pslverr)
      begin
         if (PADDR == cce_pkg::A_STATUS)
            n.status = PWDATA[7:0];
         else if (PADDR == cce_pkg::A_TC_BASE)
            n.tc_base = PWDATA;
      end
      case (s.state)
         S_IDLE:
         begin
            if (NMI_REQ)
               n.nmi_take = 1'b1;
            else if (int_pending)
               n.int_take = 1'b1;
            else if (INSN_VALID)
            begin
               n.insn = INSN_WORD;
               n.pc = INSN_PC;
               n.op = decode(INSN_WORD);
               n.state = S_READ_A;
            end
         end
         S_READ_A:
            n.state = S_READ_B;
         S_READ_B:
         begin
            n.opa = gpr_rdata;
            n.state = S_EXEC;
         end
         S_EXEC:
         begin
            n.state = S_IDLE;
            n.done = 1'b1;
            n.next_pc = s.pc + len;
            case (s.op)
               cce_pkg::OP_TCALL:
               begin
                  n.tc_pc = s.pc + len;
                  n.tc_status = s.status;
                  n.mem_addr = s.tc_base + {25'h0, s.insn[5:0], 1'b0};
                  n.mem_half = 1'b1;
                  n.mem_write = 1'b0;
                  n.mem_req = 1'b1;
                  n.done = 1'b0;
                  n.state = S_MEM_RD;
               end
               cce_pkg::OP_BCLR_D, cce_pkg::OP_BCLR_R:
               begin
                  if (s.op == cce_pkg::OP_BCLR_D)
                  begin
                     n.mem_addr = s.opa + {{16{s.insn[31]}}, s.insn[31:16]};
                     n.bit_sel = s.insn[13:11];
                  end
                  else
                  begin
                     n.mem_addr = s.opa;
                     n.bit_sel = gpr_rdata[2:0];
                  end
                  n.mem_half = 1'b0;
                  n.mem_write = 1'b0;
                  n.mem_req = 1'b1;
                  n.done = 1'b0;
                  n.state = S_MEM_RD;
               end
               cce_pkg::OP_MOVR:
               begin
                  gpr_we = 1'b1;
                  gpr_wdata = cond_met(s.insn[20:17], s.status) ? s.opa : gpr_rdata;
               end
               cce_pkg::OP_MOVI:
               begin
                  gpr_we = 1'b1;
                  gpr_wdata = cond_met(s.insn[20:17], s.status) ? sext5(s.insn[4:0])
                                                                   : gpr_rdata;
               end
               cce_pkg::OP_CMPR:
                  n.status = cmp_status(gpr_rdata, s.opa, s.status);
               cce_pkg::OP_CMPI:
                  n.status = cmp_status(gpr_rdata, sext5(s.insn[4:0]), s.status);
               cce_pkg::OP_TRET:
               begin
                  n.next_pc = s.tc_pc;
                  n.status = s.tc_status;
               end
               cce_pkg::OP_DRET:
               begin
                  n.next_pc = s.dbg_pc;
                  n.status = s.dbg_status;
               end
               cce_pkg::OP_DTRAP:
               begin
                  n.dbg_pc = s.pc + len;
                  n.dbg_status = s.status;
                  n.status[cce_pkg::FL_NMI_PEND] = 1'b1;
                  n.status[cce_pkg::FL_EXC_PEND] = 1'b1;
                  n.status[cce_pkg::FL_INT_DIS] = 1'b1;
                  n.next_pc = cce_pkg::DEBUG_VECTOR;
               end
               cce_pkg::OP_IDIS:
                  n.status[cce_pkg::FL_INT_DIS] = 1'b1;
               default:
               begin
                  n.illegal = 1'b1;
                  n.next_pc = s.pc;
               end
            endcase
         end
         S_MEM_RD:
         begin
            if (MEM_ACK)
            begin
               n.mem_req = 1'b0;
               if (s.op == cce_pkg::OP_TCALL)
               begin
                  n.state = S_IDLE;
                  n.done = 1'b1;
                  if (int_pending)
                  begin
                     n.next_pc = s.pc;
                     n.nmi_take = NMI_REQ;
                     n.int_take = !NMI_REQ;
                  end
                  else
                     n.next_pc = s.tc_base + {16'h0, MEM_RDATA};
               end
               else
               begin
                  n.status[cce_pkg::FL_ZERO] = !rbyte[s.bit_sel];
                  n.mem_wdata = rbyte & ~(8'h01 << s.bit_sel);
                  n.mem_write = 1'b1;
                  n.mem_req = 1'b1;
                  n.state = S_MEM_WR;
               end
            end
         end
         S_MEM_WR:
         begin
            if (MEM_ACK)
            begin
               n.mem_req = 1'b0;
               n.mem_write = 1'b0;
               n.done = 1'b1;
               n.next_pc = s.pc + len;
               n.state = S_IDLE;
            end
         end
         default:
            n.state = S_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
         s <= REGS_RST;
      else
         s <= n;
   end

   cce_gpr #(
      .WIDTH(32),
      .DEPTH(32),
      .AW(5)
   ) u_gpr (
      .clk(SYS_CLK),
      .we(gpr_we),
      .waddr(gpr_waddr),
      .wdata(gpr_wdata),
      .raddr(gpr_raddr),
      .rdata(gpr_rdata)
   );

   assign INSN_READY = (s.state == S_IDLE) && !int_pending;
   assign DONE = s.done;
   assign ILLEGAL = s.illegal;
   assign NEXT_PC = s.next_pc;
   assign INT_ACCEPT = s.int_take;
   assign NMI_ACCEPT = s.nmi_take;
   assign MEM_REQ = s.mem_req;
   assign MEM_WRITE = s.mem_write;
   assign MEM_HALF = s.mem_half;
   assign MEM_ADDR = s.mem_addr;
   assign MEM_WDATA = s.mem_wdata;
   assign PRDATA = s.prdata;
   assign PREADY = 1'b1;
   assign PSLVERR = s.pslverr;

   // Checks on the executed behaviour.
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   logic ast_sel_bit;
   logic [3:0] ast_keep;
   assign ast_sel_bit = MEM_RDATA[s.bit_sel];
   assign ast_keep = s.status[cce_pkg::FL_SAT:cce_pkg::FL_SIGN];

   sequence tc_exec;
      s.state == S_EXEC && s.op == cce_pkg::OP_TCALL;
   endsequence
   sequence tc_read_ok;
      s.state == S_MEM_RD && s.op == cce_pkg::OP_TCALL && MEM_ACK && !int_pending;
   endsequence
   sequence bc_read;
      s.state == S_MEM_RD && s.op != cce_pkg::OP_TCALL && MEM_ACK;
   endsequence
   sequence di_run;
      s.state == S_EXEC && s.op == cce_pkg::OP_IDIS;
   endsequence

   AST_TC_SAVE: assert property (tc_exec |=> s.tc_pc == $past(s.pc) + 32'h2
      && s.tc_status == $past(s.status))
      else $error("table call saved state wrong");
   AST_TC_ADDR: assert property (tc_exec |=> MEM_REQ && MEM_HALF && !MEM_WRITE
      && MEM_ADDR == $past(s.tc_base) + {25'h0, $past(s.insn[5:0]), 1'b0})
      else $error("table entry address wrong");
   AST_TC_TARGET: assert property (tc_read_ok |=> DONE
      && NEXT_PC == $past(s.tc_base) + {16'h0, $past(MEM_RDATA)})
      else $error("table call target wrong");
   AST_BC_CLEAR: assert property (bc_read |=> MEM_REQ && MEM_WRITE
      && !MEM_WDATA[s.bit_sel] && s.status[cce_pkg::FL_ZERO] == !$past(ast_sel_bit)
      && ast_keep == $past(ast_keep))
      else $error("bit clear result wrong");
   AST_CMP_NOWRITE: assert property (s.state == S_EXEC
      && (s.op == cce_pkg::OP_CMPR || s.op == cce_pkg::OP_CMPI) |-> !gpr_we ##1 DONE)
      else $error("compare wrote a register");
   AST_TRET: assert property (s.state == S_EXEC && s.op == cce_pkg::OP_TRET
      |=> NEXT_PC == $past(s.tc_pc) && s.status == $past(s.tc_status))
      else $error("table return restore wrong");
   AST_DTRAP: assert property (s.state == S_EXEC && s.op == cce_pkg::OP_DTRAP
      |=> DONE && NEXT_PC == cce_pkg::DEBUG_VECTOR && s.status[7:5] == 3'h7
      && s.dbg_pc == $past(s.pc) + 32'h2)
      else $error("debug trap entry wrong");
   AST_DI_MASK: assert property (di_run |=> s.status[cce_pkg::FL_INT_DIS]
      ##1 !INT_ACCEPT)
      else $error("maskable interrupt taken after disable");
   AST_NMI: assert property (s.state == S_IDLE && NMI_REQ |=> NMI_ACCEPT
      && !INT_ACCEPT)
      else $error("non-maskable interrupt not accepted");
endmodule : cce_exec

/* File: hdl/cce_gpr.sv */
// General-purpose register file, one write port and one registered read port.
// Assumes both ports run on the core clock; register 0 always reads zero.
`timescale 1ns/100ps
module cce_gpr
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32,
   parameter int AW = 5
)
(
   // Clock.
   input wire logic clk,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read port.
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we && waddr != '0)
         mem[waddr] <= wdata;
      rdata <= (raddr == '0) ? '0 : mem[raddr];
   end
endmodule : cce_gpr

/* File: hdl/cce_pkg.sv */
// Constants and types shared by the call, compare and trap execution unit.
// Assumes one core clock and a 32-bit APB path to the system registers.
// What this block does
// - Table call saves next PC and status.
// - Entry address is base plus imm6 times two.
// - Load halfword, add base, branch there.
// - Interrupt may stop table call after read.
// - Displacement bit clear: reg1 plus disp16, byte.
// - Register bit clear: reg1 address, reg2 bit.
// - Zero flag shows old bit; others kept.
// - Register move picks reg1 or reg2.
// - Immediate move picks imm5 or reg2.
// - Register compare sets flags, keeps registers.
// - Immediate compare subtracts imm5 from reg2.
// - Compare flags: borrow, overflow, sign, zero.
// - Table return restores PC and all status.
// - Debug return restores PC and status.
// - Debug trap saves next PC and status.
// - Debug trap sets pending and disable flags.
// - Debug trap jumps to fixed handler.
// - Interrupt disable sets the disable flag.
// - No interrupt sampling during interrupt disable.
// - Non-maskable interrupt ignores disable flag.
// - Debug instructions optional by configuration.
package cce_pkg;
   // Status word bit positions.
   localparam int unsigned FL_ZERO = 0;
   localparam int unsigned FL_SIGN = 1;
   localparam int unsigned FL_OVF = 2;
   localparam int unsigned FL_CARRY = 3;
   localparam int unsigned FL_SAT = 4;
   localparam int unsigned FL_INT_DIS = 5;
   localparam int unsigned FL_EXC_PEND = 6;
   localparam int unsigned FL_NMI_PEND = 7;
   // Values after reset, fixed addresses and instruction lengths.
   localparam logic [7:0] STATUS_RST = 8'h20;
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   localparam logic [31:0] DEBUG_VECTOR = 32'h0000_0060;
   localparam logic [31:0] SHORT_LEN = 32'h0000_0002;
   localparam logic [31:0] LONG_LEN = 32'h0000_0004;
   // APB byte offsets.
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_TC_PC = 8'h04;
   localparam logic [7:0] A_TC_STATUS = 8'h08;
   localparam logic [7:0] A_TC_BASE = 8'h0c;
   localparam logic [7:0] A_DBG_PC = 8'h10;
   localparam logic [7:0] A_DBG_STATUS = 8'h14;
   // Opcode fields.
   localparam logic [9:0] OPC_TCALL = 10'h008;
   localparam logic [1:0] OPC_BCLR_TOP = 2'h2;
   localparam logic [5:0] OPC_BCLR_D = 6'h3e;
   localparam logic [5:0] OPC_EXT = 6'h3f;
   localparam logic [5:0] OPC_CMPR = 6'h0f;
   localparam logic [5:0] OPC_CMPI = 6'h13;
   localparam logic [5:0] SUB_MOVR = 6'h19;
   localparam logic [5:0] SUB_MOVI = 6'h18;
   localparam logic [15:0] SUB_BCLR_R = 16'h00e4;
   localparam logic [31:0] OPC_TRET = 32'h0144_07e0;
   localparam logic [31:0] OPC_DRET = 32'h0146_07e0;
   localparam logic [31:0] OPC_IDIS = 32'h0160_07e0;
   localparam logic [15:0] OPC_DTRAP = 16'hf840;

   typedef enum logic [3:0] {
      OP_NONE, OP_TCALL, OP_BCLR_D, OP_BCLR_R, OP_MOVR, OP_MOVI,
      OP_CMPR, OP_CMPI, OP_TRET, OP_DRET, OP_DTRAP, OP_IDIS
   } cce_op_t;
endpackage : cce_pkg

/* File: test/cce_mem_model.sv */
// Byte and halfword memory model standing on the execution unit's memory port.
// Assumes requests hold until acknowledged; slow adds two wait cycles.
`timescale 1ns/100ps
module cce_mem_model
(
   // Memory bus.
   input wire logic clk,
   input wire logic req,
   input wire logic wr,
   input wire logic half,
   input wire logic [31:0] addr,
   input wire logic [7:0] wdata,
   input wire logic slow,
   output logic [15:0] rdata,
   output logic ack,
   // Last write seen.
   output logic [31:0] w_addr,
   output logic [7:0] w_data
);
   logic [1:0] cnt = 2'h0;
   initial {ack, rdata, w_addr, w_data} = '0;
   // Read data toggles when not answering so a stale value never looks valid.
   always @(posedge clk)
   begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack && cnt < {slow, 1'b0})
         cnt <= cnt + 2'h1;
      else if (req && !ack)
      begin
         cnt <= 2'h0;
         ack <= 1'b1;
         rdata <= half ? addr[15:0] ^ 16'h5a5a : {8'h00, addr[7:0] ^ 8'h5a};
         if (wr)
         begin
            w_addr <= addr;
            w_data <= wdata;
         end
      end
   end
endmodule : cce_mem_model

/* File: test/tb.sv */
// Self-checking bench for the call, compare and trap execution unit.
// Assumes the memory model above and an APB master on the core clock.
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, iv = 1'b0, irq = 1'b0, nmi = 1'b0;
   logic [7:0] paddr = 8'h00, mwd, wd;
   logic [31:0] pwd = 32'h0, prd, iw = 32'h0, ipc = 32'h0, npc, ma, wa, rv;
   logic pready, perr, irdy, done, ill, ia, na, mreq, mwr, mh, mack, e, slow = 1'b0;
   logic [15:0] mrd;
   int mismatches = 0, samples_checked = 0, cyc = 0, ni = 0, nn = 0, n0;
   initial forever #25 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      ni <= ni + ia;
      nn <= nn + na;
      if (cyc == 5000)
      begin
         mismatches++;
         stop_test();
      end
   end
   cce_exec cce_exec_inst (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr),
      .INSN_VALID(iv), .INSN_WORD(iw), .INSN_PC(ipc), .INSN_READY(irdy), .DONE(done),
      .ILLEGAL(ill), .NEXT_PC(npc), .IRQ_REQ(irq), .NMI_REQ(nmi), .INT_ACCEPT(ia),
      .NMI_ACCEPT(na), .MEM_REQ(mreq), .MEM_WRITE(mwr), .MEM_HALF(mh), .MEM_ADDR(ma),
      .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack));
   cce_mem_model cce_mem_model_inst (.clk(clk), .req(mreq), .wr(mwr), .half(mh), .addr(ma),
      .wdata(mwd), .slow(slow), .rdata(mrd), .ack(mack), .w_addr(wa), .w_data(wd));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && cyc < 5000);
      rv = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("apb_read", rv, x);
   endtask : rd
   task automatic run(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] x);
      @(posedge clk);
      iv <= 1'b1;
      iw <= w;
      ipc <= pc;
      do @(posedge clk); while (irdy !== 1'b1 && cyc < 5000);
      iv <= 1'b0;
      do @(posedge clk); while (done !== 1'b1 && cyc < 5000);
      chk("next_pc", npc, x);
   endtask : run
   task automatic bc(input logic [31:0] w, input logic [31:0] a, input logic [7:0] d);
      run(w, 32'h100, 32'h104);
      chk("wr_addr", wa, a);
      chk("wr_data", {24'h0, wd}, {24'h0, d});
   endtask : bc
   function automatic logic [31:0] mv(input logic [4:0] r3, input logic [3:0] c,
      input logic [4:0] s1, input logic [4:0] r2, input logic i);
      return {r3, i ? cce_pkg::SUB_MOVI : cce_pkg::SUB_MOVR, c, 1'b0, r2, cce_pkg::OPC_EXT, s1};
   endfunction : mv
   task automatic t_regs();
      rd(cce_pkg::A_STATUS, 32'h20);
      rd(8'h18, 32'h0);
      chk("pslverr", e, 1'b1);
      apb(1'b1, cce_pkg::A_TC_PC, 32'h55);
      rd(cce_pkg::A_TC_PC, 32'h0);
      run(32'h0, 32'h500, 32'h500);
      chk("illegal", ill, 32'h1);
      $display("test regs done");
   endtask : t_regs
   task automatic t_move_clear();
      apb(1'b1, cce_pkg::A_STATUS, 32'h1e);
      run(mv(5'd1, 4'h5, 5'h0c, 5'd0, 1'b1), 32'h100, 32'h104);
      run(mv(5'd2, 4'h5, 5'h1d, 5'd0, 1'b1), 32'h100, 32'h104);
      run(mv(5'd3, 4'h2, 5'h04, 5'd1, 1'b1), 32'h100, 32'h104);
      run(mv(5'd4, 4'h0, 5'd1, 5'd0, 1'b0), 32'h100, 32'h104);
      run(mv(5'd5, 4'h8, 5'd1, 5'd2, 1'b0), 32'h100, 32'h104);
      rd(cce_pkg::A_STATUS, 32'h1e);
      slow <= 1'b1;
      bc({cce_pkg::SUB_BCLR_R, 5'd2, cce_pkg::OPC_EXT, 5'd3}, 32'hc, 8'h56);
      slow <= 1'b0;
      rd(cce_pkg::A_STATUS, 32'h1f);
      bc({cce_pkg::SUB_BCLR_R, 5'd1, cce_pkg::OPC_EXT, 5'd4}, 32'hc, 8'h46);
      rd(cce_pkg::A_STATUS, 32'h1e);
      bc({16'h0010, cce_pkg::OPC_BCLR_TOP, 3'd3, cce_pkg::OPC_BCLR_D, 5'd5}, 32'hd, 8'h57);
      bc({16'hfffc, cce_pkg::OPC_BCLR_TOP, 3'd1, cce_pkg::OPC_BCLR_D, 5'd1}, 32'h8, 8'h50);
      rd(cce_pkg::A_STATUS, 32'h1e);
      $display("test move and clear done");
   endtask : t_move_clear
   task automatic t_cmp();
      apb(1'b1, cce_pkg::A_STATUS, 32'h14);
      run({16'h0, 5'd0, cce_pkg::OPC_CMPR, 5'd1}, 32'h200, 32'h202);
      rd(cce_pkg::A_STATUS, 32'h1a);
      run({16'h0, 5'd1, cce_pkg::OPC_CMPI, 5'h0c}, 32'h200, 32'h202);
      rd(cce_pkg::A_STATUS, 32'h11);
      bc({16'h0, cce_pkg::OPC_BCLR_TOP, 3'd0, cce_pkg::OPC_BCLR_D, 5'd1}, 32'hc, 8'h56);
      $display("test compare done");
   endtask : t_cmp
   task automatic t_call();
      apb(1'b1, cce_pkg::A_TC_BASE, 32'h100);
      apb(1'b1, cce_pkg::A_STATUS, 32'h13);
      run({16'h0, cce_pkg::OPC_TCALL, 6'h05}, 32'h200, 32'h5c50);
      rd(cce_pkg::A_TC_PC, 32'h202);
      rd(cce_pkg::A_TC_STATUS, 32'h13);
      apb(1'b1, cce_pkg::A_STATUS, 32'h00);
      run(cce_pkg::OPC_TRET, 32'h5c50, 32'h202);
      rd(cce_pkg::A_STATUS, 32'h13);
      n0 = ni;
      fork
         run({16'h0, cce_pkg::OPC_TCALL, 6'h05}, 32'h200, 32'h200);
         begin
            repeat (3) @(posedge clk);
            irq <= 1'b1;
         end
      join
      irq <= 1'b0;
      @(posedge clk);
      chk("int_on_call", ni > n0, 32'h1);
      $display("test table call done");
   endtask : t_call
   task automatic t_debug();
      apb(1'b1, cce_pkg::A_STATUS, 32'h0b);
      run({16'h0, cce_pkg::OPC_DTRAP}, 32'h300, cce_pkg::DEBUG_VECTOR);
      rd(cce_pkg::A_DBG_PC, 32'h302);
      rd(cce_pkg::A_DBG_STATUS, 32'h0b);
      rd(cce_pkg::A_STATUS, 32'heb);
      run(cce_pkg::OPC_DRET, 32'h60, 32'h302);
      rd(cce_pkg::A_STATUS, 32'h0b);
      $display("test debug done");
   endtask : t_debug
   task automatic t_int();
      apb(1'b1, cce_pkg::A_STATUS, 32'h00);
      n0 = ni;
      irq <= 1'b1;
      repeat (3) @(posedge clk);
      irq <= 1'b0;
      chk("int_taken", ni > n0, 32'h1);
      run(cce_pkg::OPC_IDIS, 32'h400, 32'h404);
      rd(cce_pkg::A_STATUS, 32'h20);
      n0 = ni;
      irq <= 1'b1;
      repeat (4) @(posedge clk);
      chk("int_masked", ni - n0, 32'h0);
      n0 = nn;
      nmi <= 1'b1;
      repeat (3) @(posedge clk);
      {irq, nmi} <= 2'b00;
      chk("nmi_taken", nn > n0, 32'h1);
      $display("test interrupts done");
   endtask : t_int
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_move_clear();
      t_cmp();
      t_call();
      t_debug();
      t_int();
      stop_test();
   end
endmodule : tb
